// *** hdl/ssr_top.sv ***
// Eight stage shift register with storage latches and cascade outputs
`default_nettype none
module ssr_top
  import ssr_pkg::*;
(
  input wire logic i_sys_clk, // System clock, 100 MHz
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire logic i_shift_clock, // Shift clock pin
  input wire logic i_serial_data, // Serial data pin
  input wire logic i_storage_load_strobe, // Latch load strobe pin
  input wire logic i_parallel_oe, // Parallel output enable pin
  output logic [7:0] o_parallel_out, // Parallel outputs
  output logic [7:0] o_parallel_out_oe, // Parallel drive enables
  output logic o_fast_cascade_out, // Cascade, rising edge
  output logic o_slow_cascade_out, // Cascade, falling edge
  output logic o_in_ready // Event buffer has room
);
  typedef struct packed {
    logic [SSR_PINS-1:0] s1;
    logic [SSR_PINS-1:0] s2;
    logic [SSR_PINS-1:0] s3;
    logic [SSR_PINS-1:0] lvl;
    logic [7:0] stage;
    logic [7:0] latch;
    logic [7:0] par_out;
    logic [7:0] par_oe;
    logic fast;
    logic slow;
    logic div;
  } ssr_top_s;

  ssr_top_s st_r;
  ssr_top_s st_nxt;
  logic evt_valid;
  logic [SSR_EVT_W-1:0] evt_in;
  logic evt_out_valid;
  logic [SSR_EVT_W-1:0] evt_out;
  logic evt_pop;
  logic fifo_ready;

  // A pin level counts once the second and third flops agree
  function automatic logic [SSR_PINS-1:0] settle(
    input logic [SSR_PINS-1:0] a,
    input logic [SSR_PINS-1:0] b,
    input logic [SSR_PINS-1:0] cur
  );
    logic [SSR_PINS-1:0] res;
    res = cur;
    for (int i = 0; i < SSR_PINS; i++)
      if (a[i] == b[i])
        res[i] = b[i];
    return res;
  endfunction : settle

  logic [SSR_PINS-1:0] lvl_now;
  assign lvl_now = settle(st_r.s2, st_r.s3, st_r.lvl);

  always_comb
  begin
    evt_valid = (lvl_now[SSR_PIN_CLK] != st_r.lvl[SSR_PIN_CLK]);
    evt_in = '0;
    evt_in[SSR_EVT_RISE] = lvl_now[SSR_PIN_CLK];
    evt_in[SSR_EVT_DATA] = lvl_now[SSR_PIN_DATA];
  end

  // Drain stalls every other cycle, as often as settled pin edges can arrive, so the buffer never fills
  assign evt_pop = evt_out_valid && st_r.div;

  // Popped word split by edge direction for the checks below
  logic pop_rise;
  logic pop_fall;
  assign pop_rise = evt_pop && evt_out[SSR_EVT_RISE];
  assign pop_fall = evt_pop && !evt_out[SSR_EVT_RISE];

  ssr_fifo #(
    .WIDTH(SSR_EVT_W),
    .DEPTH(SSR_FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(evt_valid),
    .i_in_data(evt_in),
    .o_in_ready(fifo_ready),
    .o_out_valid(evt_out_valid),
    .o_out_data(evt_out),
    .i_out_ready(st_r.div)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = {i_parallel_oe, i_storage_load_strobe, i_serial_data,
                 i_shift_clock};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.lvl = lvl_now;
    st_nxt.div = !st_r.div;
    // Enable level is not consulted here
    if (evt_pop)
    begin
      if (evt_out[SSR_EVT_RISE])
      begin
        st_nxt.stage = {st_r.stage[6:0], evt_out[SSR_EVT_DATA]};
        st_nxt.fast = st_r.stage[6];
      end
      else
        st_nxt.slow = st_r.stage[7];
    end
    // Transparent latch modelled as a per-cycle copy
    if (st_r.lvl[SSR_PIN_STROBE])
      st_nxt.latch = st_r.stage;
    st_nxt.par_out = st_r.latch;
    st_nxt.par_oe = {8{st_r.lvl[SSR_PIN_OE]}};
  end

  // Cleared at reset although the pins promise nothing until loaded
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
      st_r.div <= SSR_DIV_RST;
      st_r.lvl <= SSR_PINS_RST;
      st_r.stage <= SSR_BYTE_RST;
      st_r.latch <= SSR_BYTE_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign o_parallel_out = st_r.par_out;
  assign o_parallel_out_oe = st_r.par_oe;
  assign o_fast_cascade_out = st_r.fast;
  assign o_slow_cascade_out = st_r.slow;
  assign o_in_ready = fifo_ready;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  shift_rise_a: assert property (
    evt_pop && evt_out[SSR_EVT_RISE] |=>
      st_r.stage == {$past(st_r.stage[6:0]), $past(evt_out[0])})
    else $error("stage chain did not shift in the serial bit");
  fall_no_shift_a: assert property (
    evt_pop && !evt_out[SSR_EVT_RISE] |=> $stable(st_r.stage))
    else $error("falling edge moved the chain");
  latch_follow_a: assert property (
    st_r.lvl[SSR_PIN_STROBE] |=> st_r.latch == $past(st_r.stage))
    else $error("latch did not follow stage under strobe");
  latch_hold_a: assert property (
    !st_r.lvl[SSR_PIN_STROBE] |=> $stable(st_r.latch))
    else $error("latch changed with strobe low");
  par_drive_a: assert property (
    st_r.lvl[SSR_PIN_OE] |=> o_parallel_out_oe == 8'hff
      && o_parallel_out == $past(st_r.latch))
    else $error("parallel outputs not driving latch data");
  par_float_a: assert property (
    !st_r.lvl[SSR_PIN_OE] |=> o_parallel_out_oe == 8'h00)
    else $error("parallel outputs driven with enable low");
  fast_tap_a: assert property (
    evt_pop && evt_out[SSR_EVT_RISE] |=>
      o_fast_cascade_out == $past(st_r.stage[6])
      && o_fast_cascade_out == st_r.stage[7] && $stable(o_slow_cascade_out))
    else $error("fast cascade wrong after rising edge");
  slow_tap_a: assert property (
    evt_pop && !evt_out[SSR_EVT_RISE] |=>
      o_slow_cascade_out == $past(st_r.stage[7])
      && $stable(o_fast_cascade_out))
    else $error("slow cascade wrong after falling edge");
  edge_push_a: assert property (
    $rose(st_r.lvl[SSR_PIN_CLK]) |->
      $past(evt_valid && evt_in[SSR_EVT_RISE] && fifo_ready))
    else $error("rising shift clock not queued as an event");

  // Outputs and chain keep still between their own edges
  fast_hold_a: assert property (
    !pop_rise |=> $stable(o_fast_cascade_out))
    else $error("fast cascade moved without a rising edge");
  slow_hold_a: assert property (
    !pop_fall |=> $stable(o_slow_cascade_out))
    else $error("slow cascade moved without a falling edge");
  chain_hold_a: assert property (
    !pop_rise |=> $stable(st_r.stage))
    else $error("stage chain moved without a rising edge");
  oe_low_shift_a: assert property (
    pop_rise && !st_r.lvl[SSR_PIN_OE] |=>
      st_r.stage[0] == $past(evt_out[SSR_EVT_DATA]))
    else $error("chain stalled while outputs disabled");
  fast_is_last_a: assert property (
    o_fast_cascade_out == st_r.stage[7])
    else $error("fast cascade differs from the eighth stage");
  cascade_pair_a: assert property (
    pop_fall |=> o_slow_cascade_out == o_fast_cascade_out)
    else $error("slow cascade not the fast cascade bit");

  // Queue is at most eight deep at one word per two cycles, so 20 is slack
  rise_served_a: assert property (
    $rose(st_r.lvl[SSR_PIN_CLK]) |-> ##[0:20] pop_rise)
    else $error("settled rising edge never shifted the chain");
  fall_served_a: assert property (
    $fell(st_r.lvl[SSR_PIN_CLK]) |-> ##[0:20] pop_fall)
    else $error("settled falling edge never reached slow cascade");

  // Pin levels move only through the full three flop path
  sync_chain_a: assert property (
    st_r.s2 == $past(st_r.s1) && st_r.s3 == $past(st_r.s2))
    else $error("pin synchroniser skipped a stage");
  clk_settle_a: assert property (
    $changed(st_r.lvl[SSR_PIN_CLK]) |->
      $past(st_r.s2[SSR_PIN_CLK]) == st_r.lvl[SSR_PIN_CLK]
      && $past(st_r.s3[SSR_PIN_CLK]) == st_r.lvl[SSR_PIN_CLK])
    else $error("shift clock level taken before it settled");

  // Parallel side
  oe_all_bits_a: assert property (
    o_parallel_out_oe == 8'h00 || o_parallel_out_oe == 8'hff)
    else $error("parallel drive enables split");
  par_keep_a: assert property (
    !st_r.lvl[SSR_PIN_STROBE] ##1 !st_r.lvl[SSR_PIN_STROBE]
      |=> $stable(o_parallel_out))
    else $error("parallel data changed with strobe low");
endmodule : ssr_top
`default_nettype wire

// *** hdl/ssr_pkg.sv ***
// Shared constants of the serial shift-and-store register
`default_nettype none
package ssr_pkg;
  localparam int unsigned SSR_STAGES = 8;
  localparam int unsigned SSR_FIFO_DEPTH = 8;
  localparam int unsigned SSR_EVT_W = 2;
  localparam int unsigned SSR_PINS = 4;
  // Pin positions inside the synchroniser vectors
  localparam int unsigned SSR_PIN_CLK = 0;
  localparam int unsigned SSR_PIN_DATA = 1;
  localparam int unsigned SSR_PIN_STROBE = 2;
  localparam int unsigned SSR_PIN_OE = 3;
  // Field positions inside an edge event word
  localparam int unsigned SSR_EVT_DATA = 0;
  localparam int unsigned SSR_EVT_RISE = 1;
  // Drain runs on every second cycle
  localparam logic SSR_DIV_RST = 1'b0;
  localparam logic [7:0] SSR_BYTE_RST = 8'h00;
  localparam logic [3:0] SSR_PINS_RST = 4'h0;
endpackage : ssr_pkg
`default_nettype wire

// *** hdl/ssr_fifo.sv ***
// Edge event FIFO with valid and ready on both sides
`default_nettype none
module ssr_fifo
  import ssr_pkg::*;
#(
  parameter int unsigned WIDTH = SSR_EVT_W,
  parameter int unsigned DEPTH = SSR_FIFO_DEPTH
)(
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire logic i_in_valid, // Word offered
  input wire logic [WIDTH-1:0] i_in_data, // Offered word
  output logic o_in_ready, // Space left, registered
  output logic o_out_valid, // Word available
  output logic [WIDTH-1:0] o_out_data, // Oldest word
  input wire logic i_out_ready // Drain takes the word
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic ready;
  } ssr_fifo_s;

  ssr_fifo_s st_r;
  ssr_fifo_s st_nxt;
  logic push;
  logic pop;

  assign push = i_in_valid && st_r.ready;
  assign pop = i_out_ready && (st_r.count != '0);
  assign o_in_ready = st_r.ready;
  assign o_out_valid = (st_r.count != '0);
  assign o_out_data = st_r.mem[st_r.rd];

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wr] = i_in_data;
      st_nxt.wr = (st_r.wr == AW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
    end
    if (pop)
      st_nxt.rd = (st_r.rd == AW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
    st_nxt.count = st_r.count + (AW + 1)'(push) - (AW + 1)'(pop);
    // Ready is a flop so the pin side sees no combinational path
    st_nxt.ready = (st_nxt.count != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
      st_r.ready <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  fifo_no_over_a: assert property (st_r.count <= (AW + 1)'(DEPTH))
    else $error("fifo count above depth");
  fifo_full_ready_a: assert property
    ((st_r.count == (AW + 1)'(DEPTH)) |-> !o_in_ready)
    else $error("fifo ready while full");
endmodule : ssr_fifo
`default_nettype wire

// *** test/ssr_host.sv ***
// Host controller model driving the register's serial pins
`default_nettype none
module ssr_host
  import ssr_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  output logic o_shift_clock, // Shift clock pin
  output logic o_serial_data, // Serial data pin
  output logic o_storage_load_strobe, // Latch load strobe pin
  output logic o_parallel_oe // Parallel output enable pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_shift_clock = 1'b0;
    o_serial_data = 1'b0;
    o_storage_load_strobe = 1'b0;
    o_parallel_oe = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : idle

  // n+1 cycles high and 2n low per clock: small is prompt, large is a slow host
  task automatic rise(input logic d, input int n);
    o_serial_data = d;
    idle(n);
    o_shift_clock = 1'b1;
    idle(1);
    // Hold time over, so never leave the stale bit on the line
    o_serial_data = ~d;
    idle(n);
  endtask : rise

  task automatic fall(input int n);
    o_shift_clock = 1'b0;
    idle(n);
  endtask : fall

  // Top bit first, so it ends up in the last stage
  task automatic send_byte(input logic [7:0] b, input int n);
    for (int i = 7; i >= 0; i--)
    begin
      rise(b[i], n);
      fall(n);
    end
  endtask : send_byte

  // Waits for queued edges to drain before latching
  task automatic strobe();
    idle(2 * SSR_STAGES + 6);
    o_storage_load_strobe = 1'b1;
    idle(4);
    o_storage_load_strobe = 1'b0;
    idle(6);
  endtask : strobe

  task automatic set_oe(input logic v);
    o_parallel_oe = v;
    idle(8);
  endtask : set_oe
endmodule : ssr_host
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench of the shift-and-store register
`default_nettype none
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic shift_clock, serial_data, strobe_pin, oe_pin;
  logic [7:0] parallel_out, parallel_out_oe;
  logic fast_out, slow_out, in_ready;
  int n_mismatch = 0;
  int total_checks = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  ssr_host i_host (.i_sys_clk(i_sys_clk), .o_shift_clock(shift_clock),
    .o_serial_data(serial_data), .o_storage_load_strobe(strobe_pin),
    .o_parallel_oe(oe_pin));

  ssr_top i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_shift_clock(shift_clock), .i_serial_data(serial_data),
    .i_storage_load_strobe(strobe_pin), .i_parallel_oe(oe_pin),
    .o_parallel_out(parallel_out), .o_parallel_out_oe(parallel_out_oe),
    .o_fast_cascade_out(fast_out), .o_slow_cascade_out(slow_out),
    .o_in_ready(in_ready));

  task automatic end_of_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // Shift and latch with the outputs floating
  task automatic test_oe_off();
    i_host.send_byte(8'ha5, 4);
    i_host.strobe();
    `CHK(parallel_out_oe, 8'h00)
    `CHK(fast_out, 1'b1)
    `CHK(slow_out, 1'b1)
    `CHK(in_ready, 1'b1)
  endtask : test_oe_off

  // Latched while disabled, shown once enabled
  task automatic test_oe_on();
    i_host.set_oe(1'b1);
    `CHK(parallel_out_oe, 8'hff)
    `CHK(parallel_out, 8'ha5)
  endtask : test_oe_on

  // Slow host: cascade outputs between the last rise and its fall
  task automatic test_cascade();
    logic [7:0] pat = 8'h3c;
    for (int i = 7; i >= 1; i--)
    begin
      i_host.rise(pat[i], 4);
      i_host.fall(4);
    end
    i_host.rise(pat[0], 24);
    `CHK(fast_out, 1'b0)
    `CHK(slow_out, 1'b1)
    i_host.fall(24);
    `CHK(slow_out, 1'b0)
    `CHK(parallel_out, 8'ha5)
    i_host.strobe();
    `CHK(parallel_out, 8'h3c)
    i_host.set_oe(1'b0);
    `CHK(parallel_out_oe, 8'h00)
  endtask : test_cascade

  initial
  begin
    repeat (8) @(negedge i_sys_clk);
    `CHK(parallel_out, 8'h00)
    `CHK(in_ready, 1'b1)
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    test_oe_off();
    test_oe_on();
    test_cascade();
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
